//--- core/swd_pkg.sv
// shared constants and carrier types for the switch driver latch control
package swd_pkg;
  localparam int NUM_OUT = 10;
  localparam int CLK_NS = 50;
  // front-panel one-shot width
  localparam int ONESHOT_MS = 17;
  localparam int ONESHOT_CYC_DEF = (ONESHOT_MS * 1000000) / CLK_NS;
  localparam int ONESHOT_W = 19;
  // apb register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_BUSADR = 8'h04;
  // status field positions
  localparam int ST_LATCH_LSB = 0;
  localparam int ST_REMOTE = 16;
  localparam int ST_LOCKOUT = 17;
  localparam int ST_LISTEN = 18;
  localparam int ST_STATE_A = 19;
  localparam logic [4:0] BUSADR_RST = 5'h00;
  // interface command bytes (atn true)
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [2:0] CMD_LAG = 3'h1;
  // data bytes (atn false)
  localparam logic [7:0] DATA_A = 8'h41;
  localparam logic [7:0] DATA_B = 8'h42;
  localparam logic [7:0] DATA_ZERO = 8'h30;
  localparam logic [7:0] DATA_NINE = 8'h39;
  localparam logic [3:0] SEL_TEN = 4'h9;
  localparam logic [3:0] SEL_NONE = 4'hf;
  // sampled bus lines, positive logic
  typedef struct packed {
    logic dav;
    logic atn;
    logic ren;
    logic ifc;
    logic [7:0] dio;
  } swd_bus_t;
  // acceptor handshake states
  typedef enum logic [2:0] {
    HS_READY = 3'b001,
    HS_TAKE = 3'b010,
    HS_DONE = 3'b100
  } swd_hs_t;
endpackage

//--- core/swd_ctrl.sv
// latch, remote/local and bus listener logic of the switch driver
// What this block does
// - local mode: latches toggle on every clock
// - local: inverted one-shot pulses clock latches
// - remote: A-or-B flop steers latch inputs
// - decoder makes one clock per selected latch
// - addressed latches update on decoder clock edge
// - power-up: all latches A, local mode
// - lockout makes local button ignored
// - remote/local set only by bus, button
// - data letter sets A-or-B flop
// - handshake done strobe feeds command, lockout logic
// - nrfd, ndac from dav and permit
// - dio and atn qualified by done strobe
// - select code, strobe, remote give latch strobe
// - bus commands switch remote and local
// - one button changes only its output
// - addressed remote enable enters remote mode
// - lockout then go-to-local restores button
// - letter then digits sets listed outputs
// - non-retriggerable seventeen millisecond one-shot
// - indicators lit for A, dark for B
// - bus clear to local unless lockout
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module swd_ctrl
  import swd_pkg::*;
#(
  parameter int ONESHOT_CYC = ONESHOT_CYC_DEF
) (
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus lines, positive logic
  input wire logic bus_dav,
  input wire logic bus_atn,
  input wire logic bus_ren,
  input wire logic bus_ifc,
  input wire logic [7:0] bus_dio,
  output logic nrfd_out,
  output logic nrfd_oe,
  output logic ndac_out,
  output logic ndac_oe,
  // front panel
  input wire logic [NUM_OUT-1:0] button,
  input wire logic local_button,
  // outputs to drivers and lamps
  output logic [NUM_OUT-1:0] latch_q,
  output logic [NUM_OUT-1:0] inverted_latch_output,
  output logic remote_lamp,
  output logic local_lamp,
  output logic latch_strobe_low
);

  swd_bus_t bus_raw;
  swd_bus_t bus_s1, bus_s2, bus_s3, bus_f;
  logic [NUM_OUT:0] pan_s1, pan_s2, pan_s3, pan_f, pan_prev;
  logic [NUM_OUT-1:0] press;
  logic [NUM_OUT-1:0] pulse;
  logic [NUM_OUT-1:0] pulse_prev;
  logic [NUM_OUT-1:0] local_clk_n;
  logic local_press;
  swd_hs_t hs_state;
  logic handshake_permit;
  logic handshake_done;
  logic [7:0] byte_in;
  logic atn_in;
  logic remote;
  logic lockout;
  logic listen;
  logic state_a;
  logic [4:0] bus_address;
  logic is_cmd, is_data;
  logic cmd_mla, cmd_unl, cmd_gtl, cmd_llo;
  logic [3:0] sel_code;
  logic [NUM_OUT-1:0] dec_clk;
  logic strobe_gate;
  logic [31:0] status_word;
  logic hit_status, hit_busadr;

  assign bus_raw = '{dav: bus_dav, atn: bus_atn, ren: bus_ren, ifc: bus_ifc, dio: bus_dio};

  // three-stage pin sync; value moves once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_s1 <= '0;
      bus_s2 <= '0;
      bus_s3 <= '0;
    end else begin
      bus_s1 <= bus_raw;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_f <= '0;
    end else begin
      for (int i = 0; i < $bits(swd_bus_t); i++) begin
        if (bus_s2[i] == bus_s3[i]) begin
          bus_f[i] <= bus_s3[i];
        end
      end
    end
  end

  // same sync for the panel buttons, local button in the top bit
  always_ff @(posedge clk) begin
    if (reset) begin
      pan_s1 <= '0;
      pan_s2 <= '0;
      pan_s3 <= '0;
      pan_f <= '0;
      pan_prev <= '0;
    end else begin
      pan_s1 <= {local_button, button};
      pan_s2 <= pan_s1;
      pan_s3 <= pan_s2;
      pan_f <= (pan_s2 & pan_s3) | (pan_f & (pan_s2 ^ pan_s3));
      pan_prev <= pan_f;
    end
  end

  assign press = pan_f[NUM_OUT-1:0] & ~pan_prev[NUM_OUT-1:0];
  assign local_press = pan_f[NUM_OUT] & ~pan_prev[NUM_OUT];

  // one-shot per button; presses during a pulse are dropped
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_shot
    logic [ONESHOT_W-1:0] cnt;
    always_ff @(posedge clk) begin
      if (reset) begin
        cnt <= '0;
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end else if (press[g]) begin
        cnt <= ONESHOT_W'(ONESHOT_CYC);
      end
    end
    assign pulse[g] = (cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_prev <= '0;
    end else begin
      pulse_prev <= pulse;
    end
  end

  // local selector passes the pulse inverted; its falling edge clocks the latch
  assign local_clk_n = ~pulse;
  // one clock per pulse: low now and high in the cycle before
  wire [NUM_OUT-1:0] local_fall = ~local_clk_n & ~pulse_prev;

  // acceptor handshake: ready -> take byte -> wait for dav release
  always_ff @(posedge clk) begin
    if (reset) begin
      hs_state <= HS_READY;
    end else begin
      unique case (hs_state)
        HS_READY: begin
          if (bus_f.dav) begin
            hs_state <= HS_TAKE;
          end
        end
        HS_TAKE: begin
          hs_state <= HS_DONE;
        end
        HS_DONE: begin
          if (!bus_f.dav) begin
            hs_state <= HS_READY;
          end
        end
      endcase
    end
  end

  assign handshake_permit = (hs_state == HS_READY);
  assign handshake_done = (hs_state == HS_TAKE);
  // lines are pulled low through the enables only
  assign nrfd_out = 1'b0;
  assign ndac_out = 1'b0;
  assign nrfd_oe = bus_f.dav | ~handshake_permit;
  assign ndac_oe = ~(bus_f.dav & ~handshake_permit & ~(hs_state == HS_TAKE));

  // byte and atn as seen during the take state
  assign byte_in = bus_f.dio;
  assign atn_in = bus_f.atn;
  assign is_cmd = handshake_done & atn_in;
  assign is_data = handshake_done & ~atn_in & listen;
  assign cmd_mla = is_cmd & (byte_in[7:5] == CMD_LAG) & (byte_in[4:0] == bus_address);
  assign cmd_unl = is_cmd & (byte_in == CMD_UNL);
  assign cmd_gtl = is_cmd & listen & (byte_in == CMD_GTL);
  assign cmd_llo = is_cmd & (byte_in == CMD_LLO);

  // listen flop: set by own address, cleared by ifc, unlisten or go-to-local
  always_ff @(posedge clk) begin
    if (reset) begin
      listen <= 1'b0;
    end else if (bus_f.ifc || cmd_unl || cmd_gtl) begin
      listen <= 1'b0;
    end else if (cmd_mla) begin
      listen <= 1'b1;
    end
  end

  // lockout flop; ren release or go-to-local frees the button
  always_ff @(posedge clk) begin
    if (reset) begin
      lockout <= 1'b0;
    end else if (!bus_f.ren || cmd_gtl) begin
      lockout <= 1'b0;
    end else if (cmd_llo) begin
      lockout <= 1'b1;
    end
  end

  // remote/local flop; bus wins over the button in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      remote <= 1'b0;
    end else if (cmd_mla && bus_f.ren) begin
      remote <= 1'b1;
    end else if (!bus_f.ren || cmd_gtl) begin
      remote <= 1'b0;
    end else if (bus_f.ifc && !lockout) begin
      remote <= 1'b0;
    end else if (local_press && !lockout) begin
      remote <= 1'b0;
    end
  end

  // A-or-B flop from the state letter of a data string
  always_ff @(posedge clk) begin
    if (reset) begin
      state_a <= 1'b1;
    end else if (is_data && byte_in == DATA_A) begin
      state_a <= 1'b1;
    end else if (is_data && byte_in == DATA_B) begin
      state_a <= 1'b0;
    end
  end

  // digit to select code; digit zero picks the tenth output
  always_comb begin
    sel_code = SEL_NONE;
    if (is_data && byte_in >= DATA_ZERO && byte_in <= DATA_NINE) begin
      if (byte_in == DATA_ZERO) begin
        sel_code = SEL_TEN;
      end else begin
        sel_code = 4'(byte_in[3:0] - 4'h1);
      end
    end
  end

  // strobe only in remote, after a complete byte
  assign strobe_gate = remote & (sel_code != SEL_NONE);

  // four-to-ten decoder, one clock per latch
  always_comb begin
    dec_clk = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (strobe_gate && sel_code == 4'(i)) begin
        dec_clk[i] = 1'b1;
      end
    end
  end

  // active-low strobe registered so it never glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_strobe_low <= 1'b1;
    end else begin
      latch_strobe_low <= ~strobe_gate;
    end
  end

  // ten jk latches; local toggles, remote loads the A-or-B level
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_q <= '1;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (!remote && local_fall[i]) begin
          latch_q[i] <= ~latch_q[i];
        end else if (remote && dec_clk[i]) begin
          latch_q[i] <= state_a;
        end
      end
    end
  end

  // lamps follow the latch and mode flops
  assign inverted_latch_output = ~latch_q;
  assign remote_lamp = remote;
  assign local_lamp = ~remote;

  // apb slave: zero wait, read data captured in setup
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_busadr = (paddr == ADDR_BUSADR);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_status | hit_busadr);

  always_comb begin
    status_word = '0;
    status_word[ST_LATCH_LSB +: NUM_OUT] = latch_q;
    status_word[ST_REMOTE] = remote;
    status_word[ST_LOCKOUT] = lockout;
    status_word[ST_LISTEN] = listen;
    status_word[ST_STATE_A] = state_a;
  end

  // listen address replaces the panel address switch
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_address <= BUSADR_RST;
    end else if (psel && penable && pwrite && hit_busadr) begin
      bus_address <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (hit_status) begin
        prdata <= status_word;
      end else if (hit_busadr) begin
        prdata <= {27'h0, bus_address};
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule

//--- bench/swd_ctrl_props.sv
// port checks for the switch driver latch control
`timescale 1ns/1ns
module swd_ctrl_props
  import swd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  input wire logic [NUM_OUT-1:0] latch_q,
  input wire logic [NUM_OUT-1:0] inverted_latch_output,
  input wire logic remote_lamp,
  input wire logic local_lamp,
  input wire logic latch_strobe_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // preset must be seen right after any reset edge, so no disable here
  a_reset_preset: assert property (disable iff (1'b0) reset |=> latch_q == 10'h3ff && !remote_lamp)
    else $error("preset missing after reset");
  a_lamps_opposite: assert property (local_lamp == !remote_lamp)
    else $error("mode lamps disagree");
  a_nq_inverse: assert property (inverted_latch_output == ~latch_q)
    else $error("inverted outputs wrong");
  a_strobe_single: assert property ($fell(latch_strobe_low) |=> latch_strobe_low)
    else $error("strobe longer than one cycle");
  a_strobe_remote: assert property (!latch_strobe_low |-> remote_lamp)
    else $error("strobe outside remote");
  a_remote_load: assert property ($changed(latch_q) && $past(remote_lamp) |-> !latch_strobe_low)
    else $error("remote latch change without strobe");
  a_one_output: assert property ($changed(latch_q) |-> $onehot(latch_q ^ $past(latch_q)))
    else $error("several outputs changed at once");
  a_hs_held: assert property (nrfd_oe || ndac_oe)
    else $error("both handshake lines released");
  a_ndac_follows: assert property ($rose(nrfd_oe) |-> ##[1:3] !ndac_oe)
    else $error("byte not accepted in time");
  a_apb_err: assert property (psel && penable |-> pready && pslverr == (paddr != ADDR_STATUS && paddr != ADDR_BUSADR))
    else $error("apb answer wrong");
  c_strobe: cover property ($fell(latch_strobe_low));
  c_remote: cover property ($rose(remote_lamp));
  c_err: cover property (pslverr);
endmodule
bind swd_ctrl swd_ctrl_props u_props (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe),
  .latch_q(latch_q), .inverted_latch_output(inverted_latch_output), .remote_lamp(remote_lamp),
  .local_lamp(local_lamp), .latch_strobe_low(latch_strobe_low));

//--- bench/swd_talker.sv
// bus controller model: talker side of the three-wire handshake
`timescale 1ns/1ns
module swd_talker (
  input wire logic clk,
  input wire logic nrfd_oe,
  input wire logic ndac_oe,
  output logic dav,
  output logic atn,
  output logic [7:0] dio
);
  int slow = 0;
  // lines idle, not asserted
  initial begin
    dav = 1'b0;
    atn = 1'b0;
    dio = 8'h00;
  end
  // one byte; released data shows the inverse so stale bytes never look valid
  task automatic send(input logic a, input logic [7:0] b);
    @(posedge clk);
    while (nrfd_oe !== 1'b0) @(posedge clk);
    atn <= a;
    dio <= b;
    repeat (slow + 1) @(posedge clk);
    dav <= 1'b1;
    @(posedge clk);
    while (ndac_oe !== 1'b0) @(posedge clk);
    dav <= 1'b0;
    @(posedge clk);
    dio <= ~b;
    atn <= 1'b0;
  endtask
endmodule

//--- bench/swd_ctrl_tb.sv
// self-checking bench for the switch driver latch control
`timescale 1ns/1ns
module swd_ctrl_tb;
  import swd_pkg::*;
  typedef struct packed {
    logic atn;
    logic [7:0] dio;
    logic remote;
    logic [9:0] latch;
  } swd_row_t;
  localparam int OS_CYC = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, bus_dav, bus_atn;
  logic bus_ren = 1'b1;
  logic bus_ifc = 1'b0;
  logic [7:0] bus_dio;
  logic nrfd_out, nrfd_oe, ndac_out, ndac_oe;
  logic [NUM_OUT-1:0] button = 10'h000;
  logic local_button = 1'b0;
  logic [NUM_OUT-1:0] latch_q, inverted_latch_output;
  logic remote_lamp, local_lamp, latch_strobe_low;
  int fails = 0;
  int n_compared = 0;
  // bus byte, then mode and latches it should leave
  swd_row_t rows [11] = '{
    '{1'b1, 8'h20, 1'b1, 10'h3ff}, '{1'b0, 8'h42, 1'b1, 10'h3ff}, '{1'b0, 8'h31, 1'b1, 10'h3fe},
    '{1'b0, 8'h30, 1'b1, 10'h1fe}, '{1'b0, 8'h35, 1'b1, 10'h1ee}, '{1'b0, 8'h41, 1'b1, 10'h1ee},
    '{1'b0, 8'h31, 1'b1, 10'h1ef}, '{1'b1, 8'h3f, 1'b1, 10'h1ef}, '{1'b0, 8'h39, 1'b1, 10'h1ef},
    '{1'b1, 8'h20, 1'b1, 10'h1ef}, '{1'b0, 8'h30, 1'b1, 10'h3ef}};
  always #25 clk = ~clk;
  swd_ctrl #(.ONESHOT_CYC(OS_CYC)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_dav(bus_dav), .bus_atn(bus_atn), .bus_ren(bus_ren),
    .bus_ifc(bus_ifc), .bus_dio(bus_dio), .nrfd_out(nrfd_out), .nrfd_oe(nrfd_oe),
    .ndac_out(ndac_out), .ndac_oe(ndac_oe), .button(button), .local_button(local_button),
    .latch_q(latch_q), .inverted_latch_output(inverted_latch_output),
    .remote_lamp(remote_lamp), .local_lamp(local_lamp), .latch_strobe_low(latch_strobe_low));
  swd_talker u_talk (.clk(clk), .nrfd_oe(nrfd_oe), .ndac_oe(ndac_oe), .dav(bus_dav),
    .atn(bus_atn), .dio(bus_dio));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // apb transfer: held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // press buttons in mask {local, outputs}, wait past sync and toggle
  task automatic press(input logic [10:0] m);
    @(posedge clk);
    {local_button, button} <= m;
    repeat (3) @(posedge clk);
    {local_button, button} <= 11'h000;
    repeat (8) @(posedge clk);
  endtask
  // set ifc and ren, then wait past the three-flop sync
  task automatic lines(input logic ifc, input logic ren);
    @(posedge clk);
    bus_ifc <= ifc;
    bus_ren <= ren;
    repeat (6) @(posedge clk);
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (5) @(posedge clk);
    foreach (rows[i]) begin
      u_talk.send(rows[i].atn, rows[i].dio);
      chk("latch", {22'h0, latch_q}, {22'h0, rows[i].latch});
      chk("remote", {31'h0, remote_lamp}, {31'h0, rows[i].remote});
    end
    u_talk.slow = 4;
    u_talk.send(1'b1, CMD_LLO);
    press(11'h400);
    chk("locked", {31'h0, remote_lamp}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h000f03ef);
    u_talk.send(1'b1, CMD_GTL);
    chk("gtl", {31'h0, remote_lamp}, 32'h0);
    press(11'h008);
    chk("toggle", {22'h0, latch_q}, 32'h3e7);
    press(11'h008);
    chk("retrig", {22'h0, latch_q}, 32'h3e7);
    repeat (OS_CYC) @(posedge clk);
    press(11'h008);
    chk("toggle2", {22'h0, latch_q}, 32'h3ef);
    apb(1'b1, ADDR_BUSADR, 32'h5);
    apb(1'b0, ADDR_BUSADR, 32'h0);
    chk("busadr", rd, 32'h5);
    apb(1'b0, 8'h08, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    u_talk.send(1'b1, 8'h20);
    chk("other", {31'h0, remote_lamp}, 32'h0);
    u_talk.send(1'b1, 8'h25);
    chk("addr", {31'h0, remote_lamp}, 32'h1);
    press(11'h400);
    chk("local", {31'h0, remote_lamp}, 32'h0);
    chk("pull", {30'h0, nrfd_out, ndac_out}, 32'h0);
    // ifc under lockout keeps remote but drops listen
    u_talk.send(1'b1, 8'h25);
    u_talk.send(1'b1, CMD_LLO);
    lines(1'b1, 1'b1);
    lines(1'b0, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ifc_lock", rd, 32'h000b03ef);
    // ren release forces local and frees the button
    lines(1'b0, 1'b0);
    chk("ren_off", {31'h0, remote_lamp}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("ren_status", rd, 32'h000803ef);
    lines(1'b0, 1'b1);
    // ifc without lockout returns to local
    u_talk.send(1'b1, 8'h25);
    chk("relisten", {31'h0, remote_lamp}, 32'h1);
    lines(1'b1, 1'b1);
    lines(1'b0, 1'b1);
    chk("ifc_local", {31'h0, remote_lamp}, 32'h0);
    u_talk.send(1'b1, 8'h25);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("preset", {22'h0, latch_q}, 32'h3ff);
    chk("preset_mode", {31'h0, remote_lamp}, 32'h0);
    stop_test();
  end
endmodule
